/* File: include/sap_consts.svh */
// register offsets, field positions, reset values and timing of the serial audio port
`ifndef SAP_CONSTS_SVH
`define SAP_CONSTS_SVH
`define SAP_OFS_RVOL    8'h08
`define SAP_OFS_CFGA    8'h09
`define SAP_OFS_CFGB    8'h0a
`define SAP_OFS_SLOTL   8'h0b
`define SAP_OFS_SLOTR   8'h0c
`define SAP_RST_RVOL    8'h40
`define SAP_RST_CFGA    8'h11
`define SAP_RST_CFGB    8'h07
`define SAP_RST_SLOTL   5'h00
`define SAP_RST_SLOTR   5'h01
`define SAP_MASK_CFGA   8'h7f
`define SAP_MASK_CFGB   8'h9f
`define SAP_GAIN_MUTE   8'hff
`define SAP_SLOT_HI     4
`define SAP_A_POL       6
`define SAP_A_WID_HI    5
`define SAP_A_WID_LO    3
`define SAP_A_SENSE     2
`define SAP_A_ALIGN     1
`define SAP_A_TDM       0
`define SAP_B_DELAY     7
`define SAP_B_W16       4
`define SAP_B_ZC        3
`define SAP_B_CLINK     2
`define SAP_B_GLINK     1
`define SAP_B_AUTO      0
`define SAP_SAMPLE_BITS 7'h18
`define SAP_SHORT_BITS  7'h10
`define SAP_RST_WIDTH   7'h20
`define SAP_CLIP_BITS   4
`define SAP_H_CFG       32'h0000_0000
`define SAP_H_CMD       32'h0000_0004
`define SAP_H_STAT      32'h0000_0008
`define SAP_H_LEFT      32'h0000_000c
`define SAP_H_RIGHT     32'h0000_0010
`define SAP_H_EN        16
`define SAP_H_W16       8
`define SAP_H_DELAY     9
`define SAP_H_CMD_RD    16
`define SAP_H_BUSY      8
`define SAP_H_RST_CFG   10'h011
`define SAP_H_RST_FS    1'b1
`define SAP_AXI_OKAY    2'h0
`define SAP_AXI_SLVERR  2'h2
`define SAP_CLK_NS      25
`define SAP_BCLK_NS     200
`define SAP_BCLK_HALF   ((`SAP_BCLK_NS / 2) / `SAP_CLK_NS)
`endif

/* File: include/sap_pkg.sv */
// types and shared slot arithmetic of the serial audio port
`include "sap_consts.svh"
package sap_pkg;
	typedef logic [6:0]                sap_bits_t;
	typedef logic [`SAP_CLIP_BITS-1:0] sap_clip_t;

	typedef struct packed {
		logic [5:0] slot;
		sap_bits_t  bitn;
	} sap_pos_t;

	typedef struct packed {
		logic [7:0]  rvol;
		logic [7:0]  cfga;
		logic [7:0]  cfgb;
		logic [4:0]  slotl;
		logic [4:0]  slotr;
		logic [7:0]  rdata;
		logic        bclk_d;
		logic        fs_d;
		logic        inframe;
		sap_pos_t    pos;
		logic [23:0] sh;
		logic [23:0] lsamp;
		logic [23:0] rsamp;
		logic        strobe;
		logic [7:0]  lgain;
		logic [7:0]  rgain;
		logic        lmute;
		logic        rmute;
		sap_clip_t   lclip;
		sap_clip_t   rclip;
	} sap_dev_state_t;

	typedef struct packed {
		logic        aw_got;
		logic        w_got;
		logic        bvalid;
		logic        rvalid;
		logic [31:0] awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic [1:0]  bresp;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [9:0]  cfg;
		logic        en;
		logic [23:0] lreg;
		logic [23:0] rreg;
		logic [23:0] lsh;
		logic [23:0] rsh;
		logic        reg_wr;
		logic [7:0]  raddr;
		logic [7:0]  rwdata;
		logic [7:0]  rres;
		logic [1:0]  pend;
		logic [11:0] div;
		logic        bclk;
		logic        fs;
		logic        sd;
		logic [11:0] fbit;
		sap_pos_t    pos;
	} sap_host_state_t;

	function automatic sap_bits_t sap_slot_bits(input logic [2:0] code);
		case (code)
			3'h0: return 7'h10;
			3'h1: return 7'h18;
			3'h2: return 7'h20;
			3'h3: return 7'h30;
			3'h4: return 7'h40;
			default: return `SAP_RST_WIDTH;
		endcase
	endfunction : sap_slot_bits

	function automatic sap_bits_t sap_used_bits(input sap_bits_t w, input logic short16);
		sap_bits_t nb;
		nb = short16 ? `SAP_SHORT_BITS : `SAP_SAMPLE_BITS;
		return (w < nb) ? w : nb;
	endfunction : sap_used_bits

	function automatic sap_pos_t sap_advance(input sap_pos_t p, input sap_bits_t w);
		sap_pos_t q;
		q = p;
		if (p.bitn == w - 7'h01) begin
			q.bitn = '0;
			q.slot = p.slot + 6'h01;
		end else begin
			q.bitn = p.bitn + 7'h01;
		end
		return q;
	endfunction : sap_advance

	function automatic logic sap_tx_bit(input logic [23:0] smp, input sap_bits_t b,
			input sap_bits_t nb);
		logic [4:0] idx;
		idx = 5'h17 - b[4:0];
		return (b < nb) ? smp[idx] : 1'b0;
	endfunction : sap_tx_bit
endpackage : sap_pkg

/* File: include/sap_if.sv */
// serial audio link and register port between host and device
`timescale 1ns/1ps
interface sap_if;
	logic       bclk;
	logic       frame_sync;
	logic       serial_audio_in;
	logic       reg_wr;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;

	modport device (
		input  bclk, frame_sync, serial_audio_in, reg_wr, reg_addr, reg_wdata,
		output reg_rdata
	);
	modport host (
		output bclk, frame_sync, serial_audio_in, reg_wr, reg_addr, reg_wdata,
		input  reg_rdata
	);
endinterface : sap_if

/* File: design/sap_sync.sv */
// two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
module sap_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic [W-1:0]      o_q
);
	logic [1:0][W-1:0] st_reg;
	logic [1:0][W-1:0] st_next;

	if (W < 1) begin : g_chk
		$error("sap_sync: width must be positive");
	end

	always_comb begin
		st_next = {st_reg[0], i_d};
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_q = st_reg[1];
endmodule : sap_sync

/* File: design/sap_device.sv */
// device end: slave serial audio receiver, its registers and channel gain selection
`timescale 1ns/1ps
`include "sap_consts.svh"
module sap_device (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	sap_if.device                   bus,
	input  wire logic [7:0]         i_left_gain_code,
	input  wire sap_pkg::sap_clip_t i_left_clipper_setting,
	input  wire sap_pkg::sap_clip_t i_right_clipper_setting,
	input  wire logic [3:0]         i_address_strap_pins,
	output logic [23:0]             o_left_sample,
	output logic [23:0]             o_right_sample,
	output logic                    o_sample_strobe,
	output logic [7:0]              o_left_gain_code,
	output logic [7:0]              o_right_gain_code,
	output logic                    o_left_mute,
	output logic                    o_right_mute,
	output sap_pkg::sap_clip_t      o_left_clip,
	output sap_pkg::sap_clip_t      o_right_clip
);
	import sap_pkg::*;

	sap_dev_state_t st_reg;
	sap_dev_state_t st_next;
	logic [6:0]     sy;
	logic           bc;
	logic           fs;
	logic           sd;
	logic [3:0]     strap;

	// link pins are foreign to i_clk; all pass the same two flops so they stay aligned
	sap_sync #(
		.W (7)
	) u_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   ({i_address_strap_pins, bus.serial_audio_in, bus.frame_sync, bus.bclk}),
		.o_q   (sy)
	);
	assign {strap, sd, fs, bc} = sy;

	function automatic logic zero_cross(input logic [23:0] prev, input logic [23:0] cur);
		return (prev[23] != cur[23]) || (cur == '0);
	endfunction : zero_cross

	always_comb begin
		sap_pos_t    p;
		logic        take;
		logic        lat_l;
		logic        lat_r;
		logic [23:0] smp;
		sap_bits_t   w;
		sap_bits_t   nb;
		logic [5:0]  lslot;
		logic [5:0]  rslot;
		logic [7:0]  rtgt;
		p = st_reg.pos;
		take = 1'b0;
		lat_l = 1'b0;
		lat_r = 1'b0;
		smp = '0;
		w = '0;
		nb = '0;
		lslot = '0;
		rslot = '0;
		rtgt = '0;
		st_next = st_reg;
		st_next.strobe = 1'b0;
		st_next.bclk_d = bc;
		w = sap_slot_bits(st_reg.cfga[`SAP_A_WID_HI:`SAP_A_WID_LO]);
		nb = sap_used_bits(w, st_reg.cfgb[`SAP_B_W16]);
		if (!st_reg.cfga[`SAP_A_TDM]) begin
			lslot = 6'h00;
			rslot = 6'h01;
		end else if (st_reg.cfgb[`SAP_B_AUTO]) begin
			lslot = {1'b0, strap, 1'b0};
			rslot = {1'b0, strap, 1'b1};
		end else begin
			lslot = {1'b0, st_reg.slotl};
			rslot = {1'b0, st_reg.slotr};
		end

		// capture edge; delay moves it to the opposite bit clock edge
		if (bc != st_reg.bclk_d
				&& bc == !(st_reg.cfga[`SAP_A_POL] ^ st_reg.cfgb[`SAP_B_DELAY])) begin
			st_next.fs_d = fs;
			// the left-channel level begins a frame in both framings
			if (fs != st_reg.fs_d && fs == st_reg.cfga[`SAP_A_SENSE]) begin
				st_next.inframe = 1'b1;
				p = '0;
				take = st_reg.cfga[`SAP_A_ALIGN];
				st_next.pos = take ? sap_advance(p, w) : p;
			end else begin
				take = st_reg.inframe;
				st_next.pos = sap_advance(p, w);
			end
			if (take && p.bitn < nb) begin
				st_next.sh = {st_reg.sh[22:0], sd};
				if (p.bitn == nb - 7'h01) begin
					smp = st_next.sh << (`SAP_SAMPLE_BITS - nb);
					lat_l = (p.slot == lslot);
					lat_r = (p.slot == rslot);
				end
			end
		end
		if (lat_l) begin
			st_next.lsamp = smp;
		end
		if (lat_r) begin
			st_next.rsamp = smp;
			st_next.strobe = 1'b1;
		end

		// gain selection; crossing is judged per channel, so updates may differ in time
		rtgt = st_reg.cfgb[`SAP_B_GLINK] ? i_left_gain_code : st_reg.rvol;
		if (!st_reg.cfgb[`SAP_B_ZC] || (lat_l && zero_cross(st_reg.lsamp, smp))) begin
			st_next.lgain = i_left_gain_code;
		end
		if (!st_reg.cfgb[`SAP_B_ZC] || (lat_r && zero_cross(st_reg.rsamp, smp))) begin
			st_next.rgain = rtgt;
		end
		st_next.lmute = (st_next.lgain == `SAP_GAIN_MUTE);
		st_next.rmute = (st_next.rgain == `SAP_GAIN_MUTE);
		st_next.lclip = i_left_clipper_setting;
		st_next.rclip = st_reg.cfgb[`SAP_B_CLINK] ? i_left_clipper_setting
			: i_right_clipper_setting;

		// register port; reserved bits are masked and read as zero
		if (bus.reg_wr) begin
			case (bus.reg_addr)
				`SAP_OFS_RVOL: st_next.rvol = bus.reg_wdata;
				`SAP_OFS_CFGA: st_next.cfga = bus.reg_wdata & `SAP_MASK_CFGA;
				`SAP_OFS_CFGB: st_next.cfgb = bus.reg_wdata & `SAP_MASK_CFGB;
				`SAP_OFS_SLOTL: st_next.slotl = bus.reg_wdata[`SAP_SLOT_HI:0];
				`SAP_OFS_SLOTR: st_next.slotr = bus.reg_wdata[`SAP_SLOT_HI:0];
				default: ;
			endcase
		end
		case (bus.reg_addr)
			`SAP_OFS_RVOL: st_next.rdata = st_reg.rvol;
			`SAP_OFS_CFGA: st_next.rdata = st_reg.cfga;
			`SAP_OFS_CFGB: st_next.rdata = st_reg.cfgb;
			`SAP_OFS_SLOTL: st_next.rdata = {3'h0, st_reg.slotl};
			`SAP_OFS_SLOTR: st_next.rdata = {3'h0, st_reg.slotr};
			default: st_next.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg <= '0;
			st_reg.rvol <= `SAP_RST_RVOL;
			st_reg.cfga <= `SAP_RST_CFGA;
			st_reg.cfgb <= `SAP_RST_CFGB;
			st_reg.slotl <= `SAP_RST_SLOTL;
			st_reg.slotr <= `SAP_RST_SLOTR;
			st_reg.lgain <= `SAP_RST_RVOL;
			st_reg.rgain <= `SAP_RST_RVOL;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus.reg_rdata = st_reg.rdata;
	assign o_left_sample = st_reg.lsamp;
	assign o_right_sample = st_reg.rsamp;
	assign o_sample_strobe = st_reg.strobe;
	assign o_left_gain_code = st_reg.lgain;
	assign o_right_gain_code = st_reg.rgain;
	assign o_left_mute = st_reg.lmute;
	assign o_right_mute = st_reg.rmute;
	assign o_left_clip = st_reg.lclip;
	assign o_right_clip = st_reg.rclip;
endmodule : sap_device

/* File: design/sap_host.sv */
// host end: bit clock and frame master with an axi4-lite control slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sap_consts.svh"
module sap_host #(
	parameter int BCLK_HALF = `SAP_BCLK_HALF,
	parameter int SLOTS     = 8
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	sap_if.host              bus,
	input  wire logic [31:0] i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [31:0] i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready
);
	import sap_pkg::*;

	sap_host_state_t st_reg;
	sap_host_state_t st_next;

	// the device needs a few clocks per half bit clock to see every edge
	if (BCLK_HALF < 3 || BCLK_HALF > 4096 || SLOTS < 2 || SLOTS > 32) begin : g_chk
		$error("sap_host: unsupported parameters");
	end

	// {hit, data} for an address
	function automatic logic [32:0] reg_read(input sap_host_state_t st, input logic [31:0] a);
		case (a)
			`SAP_H_CFG: return {1'b1, 15'h0, st.en, 6'h0, st.cfg};
			`SAP_H_CMD: return {1'b1, 16'h0, st.raddr, st.rwdata};
			`SAP_H_STAT: return {1'b1, 23'h0, |st.pend, st.rres};
			`SAP_H_LEFT: return {1'b1, 8'h0, st.lreg};
			`SAP_H_RIGHT: return {1'b1, 8'h0, st.rreg};
			default: return {1'b0, 32'h0};
		endcase
	endfunction : reg_read

	always_comb begin
		logic [32:0] r;
		logic [31:0] v;
		logic        launch;
		sap_bits_t   w;
		sap_bits_t   nb;
		logic [11:0] flen;
		logic        sense;
		r = '0;
		v = '0;
		launch = 1'b0;
		w = '0;
		nb = '0;
		flen = '0;
		sense = 1'b0;
		st_next = st_reg;
		st_next.reg_wr = 1'b0;
		st_next.pend = {st_reg.pend[0], 1'b0};
		if (st_reg.pend[1]) begin
			st_next.rres = bus.reg_rdata;
		end

		// write: address and data in either order, response after both
		if (i_awvalid && !st_reg.aw_got && !st_reg.bvalid) begin
			st_next.aw_got = 1'b1;
			st_next.awaddr = i_awaddr;
		end
		if (i_wvalid && !st_reg.w_got && !st_reg.bvalid) begin
			st_next.w_got = 1'b1;
			st_next.wdata = i_wdata;
			st_next.wstrb = i_wstrb;
		end
		if (st_reg.bvalid && i_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_next.aw_got && st_next.w_got) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			r = reg_read(st_reg, st_next.awaddr);
			st_next.bresp = r[32] ? `SAP_AXI_OKAY : `SAP_AXI_SLVERR;
			for (int i = 0; i < 4; i++) begin
				v[i*8 +: 8] = st_next.wstrb[i] ? st_next.wdata[i*8 +: 8] : r[i*8 +: 8];
			end
			case (st_next.awaddr)
				`SAP_H_CFG: begin
					st_next.cfg = v[9:0];
					st_next.en = v[`SAP_H_EN];
				end
				`SAP_H_CMD: begin
					st_next.raddr = v[15:8];
					st_next.rwdata = v[7:0];
					st_next.reg_wr = !v[`SAP_H_CMD_RD];
					st_next.pend[0] = v[`SAP_H_CMD_RD];
				end
				`SAP_H_LEFT: st_next.lreg = v[23:0];
				`SAP_H_RIGHT: st_next.rreg = v[23:0];
				default: ;
			endcase
		end

		// read
		if (st_reg.rvalid && i_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (i_arvalid && !st_reg.rvalid) begin
			r = reg_read(st_reg, i_araddr);
			st_next.rvalid = 1'b1;
			st_next.rdata = r[31:0];
			st_next.rresp = r[32] ? `SAP_AXI_OKAY : `SAP_AXI_SLVERR;
		end

		// bit clock divider; data launches on the edge opposite the device's capture
		sense = st_reg.cfg[`SAP_A_SENSE];
		w = sap_slot_bits(st_reg.cfg[`SAP_A_WID_HI:`SAP_A_WID_LO]);
		nb = sap_used_bits(w, st_reg.cfg[`SAP_H_W16]);
		flen = 12'(w) * (st_reg.cfg[`SAP_A_TDM] ? 12'(SLOTS) : 12'h002);
		if (!st_reg.en) begin
			st_next.div = '0;
			st_next.bclk = 1'b0;
			st_next.fs = !sense;
			st_next.sd = 1'b0;
			st_next.fbit = '0;
		end else if (st_reg.div == 12'(BCLK_HALF - 1)) begin
			st_next.div = '0;
			st_next.bclk = !st_reg.bclk;
			launch = (st_next.bclk == (st_reg.cfg[`SAP_A_POL] ^ st_reg.cfg[`SAP_H_DELAY]));
		end else begin
			st_next.div = st_reg.div + 12'h001;
		end
		if (launch) begin
			st_next.fbit = (st_reg.fbit >= flen - 12'h001) ? 12'h000 : st_reg.fbit + 12'h001;
			if (st_reg.fbit == 12'h000) begin
				st_next.lsh = st_reg.lreg;
				st_next.rsh = st_reg.rreg;
				st_next.fs = sense;
				if (st_reg.cfg[`SAP_A_ALIGN]) begin
					st_next.sd = sap_tx_bit(st_reg.lreg, 7'h00, nb);
					st_next.pos = sap_advance('0, w);
				end else begin
					st_next.sd = 1'b0;
					st_next.pos = '0;
				end
			end else begin
				st_next.fs = (st_reg.fbit < 12'(w)) ? sense : !sense;
				if (st_reg.pos.slot == 6'h00) begin
					st_next.sd = sap_tx_bit(st_reg.lsh, st_reg.pos.bitn, nb);
				end else if (st_reg.pos.slot == 6'h01) begin
					st_next.sd = sap_tx_bit(st_reg.rsh, st_reg.pos.bitn, nb);
				end else begin
					st_next.sd = 1'b0;
				end
				st_next.pos = sap_advance(st_reg.pos, w);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg <= '0;
			st_reg.cfg <= `SAP_H_RST_CFG;
			st_reg.fs <= `SAP_H_RST_FS;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_awready = !st_reg.aw_got && !st_reg.bvalid;
	assign o_wready = !st_reg.w_got && !st_reg.bvalid;
	assign o_bvalid = st_reg.bvalid;
	assign o_bresp = st_reg.bresp;
	assign o_arready = !st_reg.rvalid;
	assign o_rvalid = st_reg.rvalid;
	assign o_rdata = st_reg.rdata;
	assign o_rresp = st_reg.rresp;
	assign bus.bclk = st_reg.bclk;
	assign bus.frame_sync = st_reg.fs;
	assign bus.serial_audio_in = st_reg.sd;
	assign bus.reg_wr = st_reg.reg_wr;
	assign bus.reg_addr = st_reg.raddr;
	assign bus.reg_wdata = st_reg.rwdata;
endmodule : sap_host

/* File: tb/sap_assertions.sv */
// concurrent checks on the register port and the serial link between host and device
`timescale 1ns/1ps
`include "sap_consts.svh"
module sap_link_assertions (
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic       bclk,
	input wire logic       frame_sync,
	input wire logic       serial_audio_in,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	sequence s_cmd(logic [7:0] a);
		reg_wr && reg_addr == a;
	endsequence
	// read data lags the address by one register stage
	sequence s_addr_settled;
		$stable(reg_addr);
	endsequence
	property p_lands(logic [7:0] a, logic [7:0] m);
		s_cmd(a) |-> ##2 reg_rdata == ($past(reg_wdata, 2) & m);
	endproperty
	property p_res(logic [7:0] a, logic [7:0] m);
		s_addr_settled ##0 (reg_addr == a) |-> (reg_rdata & m) == 8'h00;
	endproperty
	a_wr_one_pulse: assert property (reg_wr |=> !reg_wr)
		else $error("register write strobe longer than one cycle");
	a_cmd_held: assert property (reg_wr |=> ($stable(reg_addr) && $stable(reg_wdata)) [*2])
		else $error("register command changed too early");
	a_rvol_lands: assert property (p_lands(`SAP_OFS_RVOL, 8'hff))
		else $error("right gain write not visible");
	a_cfga_lands: assert property (p_lands(`SAP_OFS_CFGA, `SAP_MASK_CFGA))
		else $error("port config a write not visible");
	a_cfgb_lands: assert property (p_lands(`SAP_OFS_CFGB, `SAP_MASK_CFGB))
		else $error("port config b write not visible");
	a_slot_lands: assert property (p_lands(`SAP_OFS_SLOTL, 8'h1f))
		else $error("left slot write not visible");
	a_cfga_reserved: assert property (p_res(`SAP_OFS_CFGA, 8'h80))
		else $error("reserved bit of port config a set");
	a_cfgb_reserved: assert property (p_res(`SAP_OFS_CFGB, 8'h60))
		else $error("reserved bits of port config b set");
	a_unmapped_zero: assert property (p_res(8'h0d, 8'hff))
		else $error("unmapped register reads nonzero");
	// sync and data may not move while the bit clock stays high; from high they may only move as it falls
	a_sync_on_edge: assert property (($changed(serial_audio_in) || $changed(frame_sync))
			&& $past(bclk) |-> $fell(bclk))
		else $error("link data moved without a bit clock edge");
endmodule : sap_link_assertions

/* File: tb/sap_serial_audio_port_config_tb.sv */
// self-checking bench: host and device ends joined over the serial audio link
`timescale 1ns/1ps
`include "sap_consts.svh"
module sap_serial_audio_port_config_tb;
	import sap_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] awaddr = '0;
	logic [31:0] wdata = '0;
	logic [31:0] araddr = '0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [7:0]  lgain_in = 8'h20;
	logic [3:0]  strap_in = 4'h0;
	sap_clip_t   lclip_in = 4'h3;
	sap_clip_t   rclip_in = 4'h5;
	logic        awready, wready, bvalid, arready, rvalid, strobe, lmute, rmute;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [23:0] lsmp, rsmp;
	logic [7:0]  lgain, rgain;
	sap_clip_t   lclip, rclip;
	int          n_mismatch = 0;
	int          checks = 0;
	sap_if bus_if ();
	// four slots keep tdm frames short enough for the cycle budget
	sap_host #(.SLOTS(4)) i_sap_host (.i_clk(clk), .i_rst(rst), .bus(bus_if),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(4'hf),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
	sap_device i_sap_device (.i_clk(clk), .i_rst(rst), .bus(bus_if),
		.i_left_gain_code(lgain_in), .i_left_clipper_setting(lclip_in),
		.i_right_clipper_setting(rclip_in), .i_address_strap_pins(strap_in),
		.o_left_sample(lsmp), .o_right_sample(rsmp),
		.o_sample_strobe(strobe), .o_left_gain_code(lgain), .o_right_gain_code(rgain),
		.o_left_mute(lmute), .o_right_mute(rmute), .o_left_clip(lclip), .o_right_clip(rclip));
	sap_link_assertions u_chk (.i_clk(clk), .i_rst(rst), .bclk(bus_if.bclk),
		.frame_sync(bus_if.frame_sync), .serial_audio_in(bus_if.serial_audio_in),
		.reg_wr(bus_if.reg_wr), .reg_addr(bus_if.reg_addr), .reg_wdata(bus_if.reg_wdata),
		.reg_rdata(bus_if.reg_rdata));
	always #12.5 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	// handshakes judged at the negedge, so the ready seen is the one the edge takes
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bready && bvalid;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rready && rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
	endtask : axi_rd
	task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		axi_wr(`SAP_H_CMD, {15'h0, 1'b0, a, d}, r);
	endtask : dev_wr
	task automatic dev_rd(input logic [7:0] a, output logic [7:0] d);
		logic [31:0] v;
		logic [1:0]  r;
		axi_wr(`SAP_H_CMD, {15'h0, 1'b1, a, 8'h00}, r);
		v = 32'h100;
		while (v[`SAP_H_BUSY]) axi_rd(`SAP_H_STAT, v, r);
		d = v[7:0];
	endtask : dev_rd
	task automatic wait_strobes(input int n);
		int k;
		k = 0;
		while (k < n) begin
			@(negedge clk);
			if (strobe === 1'b1) k++;
		end
	endtask : wait_strobes
	// data launched on falling bit clock, so it is steady while the clock is high
	task automatic link_msb(input logic lvl, input int nr, input logic e);
		logic pb;
		int   k;
		k = 0;
		@(negedge clk);
		while (bus_if.frame_sync !== ~lvl) @(negedge clk);
		while (bus_if.frame_sync !== lvl) @(negedge clk);
		pb = bus_if.bclk;
		while (k < nr) begin
			@(negedge clk);
			if (bus_if.bclk && !pb) k++;
			pb = bus_if.bclk;
		end
		chk({31'h0, bus_if.serial_audio_in}, {31'h0, e});
	endtask : link_msb
	task automatic t_reset_values();
		logic [7:0]  ex [6] = '{8'h40, 8'h11, 8'h07, 8'h00, 8'h01, 8'h00};
		logic [7:0]  d;
		logic [31:0] v;
		logic [1:0]  r;
		for (int i = 0; i < 6; i++) begin
			dev_rd(8'h08 + 8'(i), d);
			chk({24'h0, d}, {24'h0, ex[i]});
		end
		axi_rd(`SAP_H_CFG, v, r);
		chk(v, {22'h0, `SAP_H_RST_CFG});
		axi_rd(32'h0000_0040, v, r);
		chk({30'h0, r}, {30'h0, `SAP_AXI_SLVERR});
		$display("reset values done");
	endtask : t_reset_values
	task automatic t_reg_access();
		logic [7:0] ad [5] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
		logic [7:0] ex [5] = '{8'h5a, 8'h7f, 8'h9f, 8'h1f, 8'h1f};
		logic [7:0] d;
		for (int i = 0; i < 5; i++) begin
			dev_wr(ad[i], (i == 0) ? 8'h5a : 8'hff);
			dev_rd(ad[i], d);
			chk({24'h0, d}, {24'h0, ex[i]});
		end
		dev_wr(`SAP_OFS_SLOTL, 8'h00);
		dev_wr(`SAP_OFS_SLOTR, 8'h01);
		$display("register access done");
	endtask : t_reg_access
	task automatic t_gain_clip();
		dev_wr(`SAP_OFS_CFGB, 8'h01);
		dev_wr(`SAP_OFS_RVOL, `SAP_GAIN_MUTE);
		repeat (4) @(negedge clk);
		chk({24'h0, rgain}, 32'hff);
		chk({31'h0, rmute}, 32'h1);
		chk({28'h0, rclip}, 32'h5);
		chk({24'h0, lgain}, 32'h20);
		chk({31'h0, lmute}, 32'h0);
		chk({28'h0, lclip}, 32'h3);
		dev_wr(`SAP_OFS_CFGB, 8'h07);
		repeat (4) @(negedge clk);
		chk({24'h0, rgain}, 32'h20);
		chk({31'h0, rmute}, 32'h0);
		chk({28'h0, rclip}, 32'h3);
		$display("gain and clipper done");
	endtask : t_gain_clip
	task automatic run_stream(input logic [7:0] a, input logic [7:0] b, input logic [1:0] h,
			input logic [23:0] l, input logic [23:0] r, input logic [23:0] el,
			input logic [23:0] er);
		logic [1:0] rs;
		dev_wr(`SAP_OFS_CFGA, a);
		dev_wr(`SAP_OFS_CFGB, b);
		axi_wr(`SAP_H_LEFT, {8'h0, l}, rs);
		axi_wr(`SAP_H_RIGHT, {8'h0, r}, rs);
		axi_wr(`SAP_H_CFG, {15'h0, 1'b1, 6'h0, h, 1'b0, a[6:0]}, rs);
		if (!a[6] && !b[7]) begin
			link_msb(a[2], a[1] ? 1 : 2, l[23]);
		end
		// first frame after enable may be partial
		wait_strobes(3);
		chk({8'h0, lsmp}, {8'h0, el});
		chk({8'h0, rsmp}, {8'h0, er});
		axi_wr(`SAP_H_CFG, {22'h0, h, 1'b0, a[6:0]}, rs);
	endtask : run_stream
	task automatic t_stream_modes();
		run_stream(8'h11, 8'h07, 2'h0, 24'h9abcde, 24'h13579b, 24'h9abcde, 24'h13579b);
		run_stream(8'h10, 8'h07, 2'h0, 24'h2468ac, 24'hfedcba, 24'h2468ac, 24'hfedcba);
		run_stream(8'h16, 8'h07, 2'h0, 24'hc0ffee, 24'h0badf0, 24'hc0ffee, 24'h0badf0);
		run_stream(8'h43, 8'h07, 2'h0, 24'h87654f, 24'h4321ab, 24'h876500, 24'h432100);
		run_stream(8'h21, 8'h07, 2'h0, 24'h55aa33, 24'h33cc55, 24'h55aa33, 24'h33cc55);
		run_stream(8'h0e, 8'h07, 2'h0, 24'hf0e1d2, 24'h0f1e2d, 24'hf0e1d2, 24'h0f1e2d);
		run_stream(8'h19, 8'h17, 2'h1, 24'h89abff, 24'h7654ee, 24'h89ab00, 24'h765400);
		run_stream(8'h11, 8'h87, 2'h2, 24'hd00d11, 24'h2bad22, 24'hd00d11, 24'h2bad22);
		run_stream(8'h55, 8'h07, 2'h0, 24'ha1b2c3, 24'h1a2b3c, 24'ha1b2c3, 24'h1a2b3c);
		dev_wr(`SAP_OFS_SLOTL, 8'h01);
		dev_wr(`SAP_OFS_SLOTR, 8'h00);
		run_stream(8'h11, 8'h06, 2'h0, 24'h600df0, 24'h0dd0ba, 24'h0dd0ba, 24'h600df0);
		// auto slots from strap 1 pick empty slots 2 and 3 over the swapped fields
		strap_in <= 4'h1;
		run_stream(8'h11, 8'h07, 2'h0, 24'h600df0, 24'h0dd0ba, 24'h000000, 24'h000000);
		strap_in <= 4'h0;
		dev_wr(`SAP_OFS_SLOTL, 8'h00);
		dev_wr(`SAP_OFS_SLOTR, 8'h01);
		$display("stream modes done");
	endtask : t_stream_modes
	task automatic t_zero_cross();
		logic [1:0] rs;
		dev_wr(`SAP_OFS_CFGA, 8'h11);
		dev_wr(`SAP_OFS_CFGB, 8'h01);
		dev_wr(`SAP_OFS_RVOL, 8'h40);
		axi_wr(`SAP_H_RIGHT, 32'h0010_0000, rs);
		axi_wr(`SAP_H_CFG, 32'h0001_0011, rs);
		wait_strobes(2);
		dev_wr(`SAP_OFS_CFGB, 8'h09);
		dev_wr(`SAP_OFS_RVOL, 8'h30);
		wait_strobes(2);
		chk({24'h0, rgain}, 32'h40);
		axi_wr(`SAP_H_RIGHT, 32'h0, rs);
		wait_strobes(3);
		chk({24'h0, rgain}, 32'h30);
		axi_wr(`SAP_H_CFG, 32'h0000_0011, rs);
		$display("zero crossing done");
	endtask : t_zero_cross
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset_values();
		t_reg_access();
		t_gain_clip();
		t_stream_modes();
		t_zero_cross();
		finish_test();
	end
	// tests need roughly 40k cycles; cut off at 90k
	initial begin
		#2_250_000;
		n_mismatch++;
		finish_test();
	end
endmodule : sap_serial_audio_port_config_tb
